// ### scpcd_pkg.sv
// shared constants and types for the serial command port with change detect
package scpcd_pkg;
    // frame layout
    localparam int FRAME_W   = 16;
    localparam int ADDR_W    = 7;
    localparam int DATA_W    = 8;
    localparam int RW_BIT    = 15;
    localparam int NUM_WATCH = 7;
    localparam int NUM_PCFG  = 7;
    localparam int PCFG_IW   = 3;
    localparam int PCFG_FW   = 2;

    // command address codes
    localparam logic [6:0] ADDR_NOOP    = 7'h00;
    localparam logic [6:0] ADDR_CFG     = 7'h04;
    localparam logic [6:0] ADDR_MASK    = 7'h06;
    localparam logic [6:0] ADDR_PCFG_LO = 7'h09;
    localparam logic [6:0] ADDR_PCFG_HI = 7'h0F;

    // configuration register fields
    localparam int CFG_RUN_BIT = 0;
    localparam int CFG_ARM_BIT = 7;

    // reset values: shutdown, nothing watched, every port an input
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [6:0] MASK_RST = 7'h00;
    localparam logic [7:0] PCFG_RST = 8'hAA;
    localparam logic [1:0] PCFG_BAD = 2'h0;
    localparam logic [7:0] RD_ZERO  = 8'h00;

    // one command frame
    typedef struct packed {
        logic       rd;
        logic [6:0] addr;
        logic [7:0] data;
    } scpcd_frame_t;

    // the three link pins
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } scpcd_link_t;

    // everything sampled from outside the clock domain
    typedef struct packed {
        scpcd_link_t     link;
        logic [6:0]      watch;
    } scpcd_pins_t;
endpackage

// ### scpcd_top.sv
// serial command port slave with one-shot change detection on watched ports
// Operation
// - frame: address byte high, data byte low
// - input bit reappears on output 15.5 clocks later
// - shift data in on rising clock while selected
// - deselected clock edges change nothing
// - select rise latches sixteen bits, then executes
// - only the last sixteen bits count
// - read flag high, data byte discarded
// - read loads addressed register into low byte
// - power-up resets registers, enters shutdown
// - any masked change while armed raises alert high
// - mask bit set watches that port
// - arm write always retakes port snapshot
// - arm write enables detection, lowers alert; a change in that cycle wins
// - mismatch latches alert until cleared
// - only a mask register access or an arm write clears alert
// - alert trip disarms until next arm write
// - clock and data pins ignored outside select low period
// - two-bit port fields, 00 never taken
`timescale 1ns/1ps
module scpcd_top
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    // serial link pins
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  din,
    output logic                       dout,
    // watched port levels
    input  wire logic [6:0]            watched_ports,
    // status and configuration out
    output logic                       alert_port,
    output logic                       shutdown,
    output logic                       detect_en,
    output logic [6:0]                 watch_mask,
    output logic [6:0][7:0]            port_cfg
);

    // sampled pins, three stages each
    scpcd_pkg::scpcd_pins_t pins_in;
    scpcd_pkg::scpcd_pins_t sy1_ff;
    scpcd_pkg::scpcd_pins_t sy2_ff;
    scpcd_pkg::scpcd_pins_t sy3_ff;
    scpcd_pkg::scpcd_pins_t flt_ff;
    scpcd_pkg::scpcd_pins_t nxt_flt;
    scpcd_pkg::scpcd_pins_t prv_ff;

    // serial engine
    logic [15:0]               sr_ff;
    scpcd_pkg::scpcd_frame_t   latch_ff;
    logic                      exec_ff;
    logic                      dout_ff;
    logic                      sclk_rise;
    logic                      sclk_fall;
    logic                      cs_rise;
    logic                      selected;

    // register file
    logic [7:0]                cfg_ff;
    logic [6:0]                mask_ff;
    logic [6:0][7:0]           pcfg_ff;
    logic [6:0][7:0]           nxt_pcfg;
    logic [6:0]                snap_ff;
    logic                      en_ff;
    logic                      alert_ff;

    // decode of the latched frame
    logic                      is_cfg;
    logic                      is_mask;
    logic                      is_pcfg;
    logic [6:0]                pcfg_off;
    logic [2:0]                pcfg_idx;
    logic [7:0]                rd_data;
    logic                      arm_wr;
    logic                      disarm_wr;
    logic                      mask_acc;
    logic [6:0]                mismatch;
    logic                      change;

    assign pins_in.link.sclk = sclk;
    assign pins_in.link.cs_n = cs_n;
    assign pins_in.link.din  = din;
    assign pins_in.watch     = watched_ports;

    // three-stage sampling of every outside pin
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sy1_ff           <= '0;
            sy1_ff.link.cs_n <= 1'b1;
            sy2_ff           <= '0;
            sy2_ff.link.cs_n <= 1'b1;
            sy3_ff           <= '0;
            sy3_ff.link.cs_n <= 1'b1;
        end
        else
        begin
            sy1_ff <= pins_in;
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
        end
    end

    // a pin counts as changed once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < $bits(scpcd_pkg::scpcd_pins_t); gi++)
        begin : g_flt
            assign nxt_flt[gi] = (sy2_ff[gi] == sy3_ff[gi]) ? sy3_ff[gi] : flt_ff[gi];
        end
    endgenerate

    // filtered pins and their previous value; select idles high
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            flt_ff           <= '0;
            flt_ff.link.cs_n <= 1'b1;
            prv_ff           <= '0;
            prv_ff.link.cs_n <= 1'b1;
        end
        else
        begin
            flt_ff <= nxt_flt;
            prv_ff <= flt_ff;
        end
    end

    // edges of the link pins; clock edges only inside a select-low period, select rise at its end
    assign selected  = !flt_ff.link.cs_n && !prv_ff.link.cs_n;
    assign sclk_rise = selected && flt_ff.link.sclk && !prv_ff.link.sclk;
    assign sclk_fall = selected && !flt_ff.link.sclk && prv_ff.link.sclk;
    assign cs_rise   = flt_ff.link.cs_n && !prv_ff.link.cs_n;

    // shift register, and read data load one cycle after select rises
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sr_ff <= '0;
        end
        else if (sclk_rise)
        begin
            sr_ff <= {sr_ff[scpcd_pkg::FRAME_W - 2:0], flt_ff.link.din};
        end
        else if (exec_ff && latch_ff.rd)
        begin
            sr_ff[scpcd_pkg::DATA_W - 1:0] <= rd_data;
        end
    end

    // holding latch and execute strobe on select rise
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            latch_ff <= '0;
            exec_ff  <= 1'b0;
        end
        else
        begin
            exec_ff <= cs_rise;
            if (cs_rise)
            begin
                latch_ff <= sr_ff;
            end
        end
    end

    // chain output changes on the falling serial clock
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            dout_ff <= 1'b0;
        end
        else if (sclk_fall)
        begin
            dout_ff <= sr_ff[scpcd_pkg::FRAME_W - 1];
        end
    end

    // frame decode
    assign is_cfg   = latch_ff.addr == scpcd_pkg::ADDR_CFG;
    assign is_mask  = latch_ff.addr == scpcd_pkg::ADDR_MASK;
    assign is_pcfg  = (latch_ff.addr >= scpcd_pkg::ADDR_PCFG_LO) && (latch_ff.addr <= scpcd_pkg::ADDR_PCFG_HI);
    assign pcfg_off = latch_ff.addr - scpcd_pkg::ADDR_PCFG_LO;
    assign pcfg_idx = pcfg_off[scpcd_pkg::PCFG_IW - 1:0];

    // write strobes and the mask access strobe, which a read also fires; reads never touch the data byte
    assign arm_wr    = exec_ff && !latch_ff.rd && is_cfg && latch_ff.data[scpcd_pkg::CFG_ARM_BIT];
    assign disarm_wr = exec_ff && !latch_ff.rd && is_cfg && !latch_ff.data[scpcd_pkg::CFG_ARM_BIT];
    assign mask_acc  = exec_ff && is_mask;

    // read-back selection
    always_comb
    begin
        rd_data = scpcd_pkg::RD_ZERO;
        if (is_cfg)
        begin
            rd_data = cfg_ff;
        end
        else if (is_mask)
        begin
            rd_data = {1'b0, mask_ff};
        end
        else if (is_pcfg)
        begin
            rd_data = pcfg_ff[pcfg_idx];
        end
    end

    // configuration and mask registers; power-up leaves shutdown set
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_ff  <= scpcd_pkg::CFG_RST;
            mask_ff <= scpcd_pkg::MASK_RST;
        end
        else if (exec_ff && !latch_ff.rd)
        begin
            if (is_cfg)
            begin
                cfg_ff <= latch_ff.data;
            end
            if (is_mask)
            begin
                mask_ff <= latch_ff.data[scpcd_pkg::NUM_WATCH - 1:0];
            end
        end
    end

    // port configuration fields; a 00 field leaves the old setting
    genvar gr;
    genvar gf;
    generate
        for (gr = 0; gr < scpcd_pkg::NUM_PCFG; gr++)
        begin : g_pcfg
            for (gf = 0; gf < scpcd_pkg::DATA_W / scpcd_pkg::PCFG_FW; gf++)
            begin : g_fld
                localparam int FLSB = gf * scpcd_pkg::PCFG_FW;
                logic [scpcd_pkg::PCFG_FW - 1:0] new_fld;
                logic                            wr_fld;
                assign new_fld = latch_ff.data[FLSB +: scpcd_pkg::PCFG_FW];
                assign wr_fld  = exec_ff && !latch_ff.rd && is_pcfg && (pcfg_idx == 3'(gr))
                                 && (new_fld != scpcd_pkg::PCFG_BAD);
                assign nxt_pcfg[gr][FLSB +: scpcd_pkg::PCFG_FW] = wr_fld ? new_fld
                                                                         : pcfg_ff[gr][FLSB +: scpcd_pkg::PCFG_FW];
            end
        end
    endgenerate

    // port configuration registers; every port an input after power-up
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pcfg_ff <= {scpcd_pkg::NUM_PCFG{scpcd_pkg::PCFG_RST}};
        end
        else
        begin
            pcfg_ff <= nxt_pcfg;
        end
    end

    // per-port mismatch against the snapshot, gated by the mask
    generate
        for (gi = 0; gi < scpcd_pkg::NUM_WATCH; gi++)
        begin : g_cmp
            assign mismatch[gi] = mask_ff[gi] && (flt_ff.watch[gi] != snap_ff[gi]);
        end
    endgenerate
    assign change = en_ff && (|mismatch);

    // snapshot taken on every arm write
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            snap_ff <= '0;
        end
        else if (arm_wr)
        begin
            snap_ff <= flt_ff.watch;
        end
    end

    // detection enable: a trip in the arm cycle still disarms, matching the alert
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            en_ff <= 1'b0;
        end
        else if (change)
        begin
            en_ff <= 1'b0;
        end
        else if (arm_wr)
        begin
            en_ff <= 1'b1;
        end
        else if (disarm_wr)
        begin
            en_ff <= 1'b0;
        end
    end

    // alert latch; a change in the clearing cycle wins
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            alert_ff <= 1'b0;
        end
        else if (change)
        begin
            alert_ff <= 1'b1;
        end
        else if (arm_wr || mask_acc)
        begin
            alert_ff <= 1'b0;
        end
    end

    // outputs
    assign dout       = dout_ff;
    assign alert_port = alert_ff;
    assign shutdown   = !cfg_ff[scpcd_pkg::CFG_RUN_BIT];
    assign detect_en  = en_ff;
    assign watch_mask = mask_ff;
    assign port_cfg   = pcfg_ff;

endmodule

// ### scpcd_monitor.sv
// port checks for the serial command port with change detect
`timescale 1ns/1ps
module scpcd_monitor
(
    // clock and reset
    input wire logic            mclk,
    input wire logic            nrst,
    // link pins
    input wire logic            sclk,
    input wire logic            cs_n,
    input wire logic            din,
    input wire logic            dout,
    // ports and status
    input wire logic [6:0]      watched_ports,
    input wire logic            alert_port,
    input wire logic            shutdown,
    input wire logic            detect_en,
    input wire logic [6:0]      watch_mask,
    input wire logic [6:0][7:0] port_cfg
);
    logic bad_fld;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // any port field left at 00
    always_comb
    begin
        bad_fld = 1'b0;
        for (int i = 0; i < 28; i++)
            bad_fld = bad_fld | (port_cfg[i/4][(i%4)*2+:2] == 2'b00);
    end
    // the alert latch trips
    sequence s_trip;
        $rose(alert_port);
    endsequence
    chk_trip_disarms: assert property (s_trip |-> $fell(detect_en)) else $error("trip kept armed");
    chk_trip_needs_en: assert property (s_trip |-> $past(detect_en)) else $error("trip unarmed");
    chk_armed_low: assert property (detect_en |-> !alert_port) else $error("armed with alert");
    chk_clear_exec: assert property ($fell(alert_port) |-> $past(cs_n) && $past(cs_n, 4))
        else $error("alert cleared off frame");
    chk_regs_exec: assert property (!$stable({shutdown, watch_mask, port_cfg}) |-> $past(cs_n) && $past(cs_n, 4))
        else $error("register moved in frame");
    chk_rst_values: assert property ($rose(nrst) |-> shutdown && !detect_en && watch_mask == 7'h00)
        else $error("bad reset state");
    chk_idle_dout: assert property (cs_n [*8] |=> $stable(dout)) else $error("dout moved idle");
    chk_no_bad_fld: assert property (!bad_fld) else $error("port field 00");
    chk_arm_exec: assert property ($rose(detect_en) |-> $past(cs_n, 4) && !alert_port)
        else $error("arm off frame");
endmodule
bind scpcd_top scpcd_monitor u_mon (.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .watched_ports(watched_ports), .alert_port(alert_port), .shutdown(shutdown),
    .detect_en(detect_en), .watch_mask(watch_mask), .port_cfg(port_cfg));

// ### scpcd_host.sv
// host model driving the link pins
`timescale 1ns/1ps
module scpcd_host
(
    // clock
    input  wire logic mclk,
    // link pins
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    // idle: clock low, deselected
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // half of the 48 ns link period
    task automatic half();
        repeat (6) @(posedge mclk);
    endtask
    // select falls with clock low
    task automatic start();
        half();
        cs_n <= 1'b0;
        half();
    endtask
    // sixteen bits msb first, dout taken at each rise
    task automatic shift(input logic [15:0] w, output logic [15:0] r);
        for (int i = 15; i >= 0; i--)
        begin
            din <= w[i];
            half();
            sclk <= 1'b1;
            r[i] = dout;
            half();
            sclk <= 1'b0;
        end
        half();
    endtask
    // select rises, data line turned over
    task automatic stop();
        cs_n <= 1'b1;
        din  <= ~din;
        repeat (10) @(posedge mclk);
    endtask
    // clock and data toggled while deselected
    task automatic noise();
        repeat (16)
        begin
            sclk <= ~sclk;
            din  <= ~din;
            half();
        end
    endtask
endmodule

// ### testbench.sv
// self-checking bench for the serial command port with change detect
`timescale 1ns/1ps
module testbench;
    logic            mclk;
    logic            nrst;
    logic            sclk;
    logic            cs_n;
    logic            din;
    logic            dout;
    logic [6:0]      watched_ports;
    logic            alert_port;
    logic            shutdown;
    logic            detect_en;
    logic [6:0]      watch_mask;
    logic [6:0][7:0] port_cfg;
    logic [15:0]     rx;
    int              failures;
    int              compares;
    scpcd_top dut (.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .watched_ports(watched_ports), .alert_port(alert_port), .shutdown(shutdown),
        .detect_en(detect_en), .watch_mask(watch_mask), .port_cfg(port_cfg));
    scpcd_host host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    // 250 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // one comparison
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one whole frame
    task automatic frame(input logic [15:0] w);
        host.start();
        host.shift(w, rx);
        host.stop();
    endtask
    // bounded wait for an alert level
    task automatic wait_alert(input logic lvl);
        for (int n = 0; n < 40 && alert_port !== lvl; n++)
            @(posedge mclk);
        chk("alert", 16'(lvl), 16'(alert_port));
    endtask
    // change watched ports, settle, check alert
    task automatic poke(input logic [6:0] v, input logic lvl);
        watched_ports <= v;
        repeat (20) @(posedge mclk);
        chk("alert", 16'(lvl), 16'(alert_port));
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        failures = 0;
        compares = 0;
        nrst = 1'b0;
        watched_ports = 7'h00;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        repeat (8) @(posedge mclk);
        chk("shutdown", 16'h0001, 16'(shutdown));
        chk("mask", 16'h0000, 16'(watch_mask));
        for (int i = 0; i < 7; i++)
            chk("port_cfg", 16'h00AA, 16'(port_cfg[i]));
        frame(16'h0401);
        chk("shutdown", 16'h0000, 16'(shutdown));
        host.start();
        host.shift(16'h067F, rx);
        host.shift(16'h0655, rx);
        chk("echo", 16'h067F, rx);
        host.stop();
        chk("mask", 16'h0055, 16'(watch_mask));
        host.noise();
        frame(16'h0F4A);
        chk("idle echo", 16'h0655, rx);
        chk("port_cfg", 16'h006A, 16'(port_cfg[6]));
        frame(16'h0481);
        chk("detect_en", 16'h0001, 16'(detect_en));
        poke(7'h02, 1'b0);
        watched_ports <= 7'h03;
        wait_alert(1'b1);
        chk("detect_en", 16'h0000, 16'(detect_en));
        poke(7'h02, 1'b1);
        frame(16'h0000);
        chk("alert", 16'h0001, 16'(alert_port));
        frame(16'h86AB);
        chk("alert", 16'h0000, 16'(alert_port));
        frame(16'h0000);
        chk("readback", 16'h0055, {8'h00, rx[7:0]});
        chk("mask", 16'h0055, 16'(watch_mask));
        poke(7'h03, 1'b0);
        frame(16'h0481);
        poke(7'h03, 1'b0);
        watched_ports <= 7'h02;
        wait_alert(1'b1);
        stop_test();
    end
endmodule
